// File: rtl/scd_divider.sv
// Selectable clock divider: picks one of two input clocks and derives two
// groups of phase-aligned divided clocks from its rising edges.
// Assumes the chosen input clock runs below half of ref_clk so that each
// of its levels is seen for at least one sampling edge.
module scd_divider #(
    parameter int NUM_HALF = scd_pkg::NUM_HALF,
    parameter int NUM_QUARTER = scd_pkg::NUM_QUARTER
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire scd_pkg::scd_pins_t pins,
    output logic [NUM_HALF-1:0] half_rate_outs,
    output logic [NUM_QUARTER-1:0] quarter_rate_outs
);

    ////////////////////////////////////////////////////////////////////////////
    // Input capture.

    scd_pkg::scd_pins_t pins_s;
    logic [scd_pkg::PINS_W-1:0] pins_q;

    // Every pin is asynchronous, so all of them cross through two flops.
    scd_sync #(
        .WIDTH(scd_pkg::PINS_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d(pins),
        .q(pins_q)
    );

    assign pins_s = pins_q;

    logic rst_sync_n;

    // The reset pin is released through two flops, so the divider leaves reset
    // on one sampling edge; the pin synchroniser above is released two edges
    // earlier and already holds settled pin levels when the divider starts.
    // Assertion of reset still reaches every flop at once, without a clock.
    scd_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Differential receiver and source selection.

    logic true_eff;
    logic comp_eff;
    logic pecl_level;
    logic next_pecl_level;
    logic sel_level;
    logic prev_level;
    logic next_prev_level;
    logic clk_rise;

    // A floating line falls to its resting level instead of an unknown one.
    always_comb begin
        true_eff = pins_s.pecl_true_driven ? pins_s.pecl_true_in
                                           : scd_pkg::PECL_OPEN_TRUE;
        comp_eff = pins_s.pecl_comp_driven ? pins_s.pecl_comp_in
                                           : scd_pkg::PECL_OPEN_COMP;
        // Equal lines carry no differential information, so the level holds.
        if (true_eff != comp_eff) begin
            next_pecl_level = true_eff;
        end else begin
            next_pecl_level = pecl_level;
        end
    end

    // The chosen source; a change of choice may itself look like an edge.
    always_comb begin
        sel_level = (pins_s.src_sel == scd_pkg::SEL_TTL) ? pins_s.ttl_clock_in
                                                         : pecl_level;
        next_prev_level = sel_level;
        clk_rise = sel_level && !prev_level;
    end

    // Both levels start high: an input that is already high at reset release
    // would otherwise be counted as a rising edge that never happened.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pecl_level <= scd_pkg::ARM_LEVEL_RST;
            prev_level <= scd_pkg::ARM_LEVEL_RST;
        end else begin
            pecl_level <= next_pecl_level;
            prev_level <= next_prev_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Common phase counter and output registers.

    logic [scd_pkg::PHASE_W-1:0] phase;
    logic [scd_pkg::PHASE_W-1:0] next_phase;
    logic [NUM_HALF-1:0] next_half;
    logic [NUM_QUARTER-1:0] next_quarter;

    // One counter feeds both groups, which keeps their rising edges on the
    // same sampling edge; quarter = phase[1]^phase[0] rises with phase 0->1.
    always_comb begin
        next_phase = clk_rise ? phase + scd_pkg::PHASE_STEP : phase;
        next_half = {NUM_HALF{next_phase[0]}};
        next_quarter = {NUM_QUARTER{next_phase[1] ^ next_phase[0]}};
    end

    // Reset clears the counter and outputs together without a clock.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase <= scd_pkg::PHASE_RST;
            half_rate_outs <= {NUM_HALF{scd_pkg::LEVEL_RST}};
            quarter_rate_outs <= {NUM_QUARTER{scd_pkg::LEVEL_RST}};
        end else begin
            phase <= next_phase;
            half_rate_outs <= next_half;
            quarter_rate_outs <= next_quarter;
        end
    end

    initial begin
        if (NUM_HALF < 1 || NUM_QUARTER < 1) begin
            $error("scd_divider: each output group needs at least one output");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    // Every edge that sees the reset pin low also sees every output low.
    property p_reset_hold;
        @(posedge ref_clk)
        !rst_n |-> (half_rate_outs == '0) && (quarter_rate_outs == '0);
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("outputs high during reset");

    property p_reset_low;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        $rose(rst_sync_n) |-> (half_rate_outs == '0) && (quarter_rate_outs == '0)
            && (phase == scd_pkg::PHASE_RST);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("outputs not low after reset");

    // The first edge after release is left out: its past pin sample is the
    // synchroniser's reset value, not the pin, so a high pin looks like a rise.
    property p_src_ttl;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        ($past(rst_sync_n) && pins_s.src_sel && $stable(pins_s.src_sel)
            && $rose(pins_s.ttl_clock_in))
            |-> clk_rise ##1 (half_rate_outs[0] != $past(half_rate_outs[0]));
    endproperty
    a_src_ttl: assert property (p_src_ttl) else $error("TTL edge not taken");

    property p_src_pecl;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        (!pins_s.src_sel && $stable(pins_s.src_sel) && $rose(pecl_level)) |-> clk_rise;
    endproperty
    a_src_pecl: assert property (p_src_pecl) else $error("PECL edge not taken");

    // An open pair brings the receiver to its low resting level by the next edge.
    property p_pecl_open;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        (rst_sync_n && !pins_s.pecl_true_driven && !pins_s.pecl_comp_driven) |=> !pecl_level;
    endproperty
    a_pecl_open: assert property (p_pecl_open) else $error("open pair not at rest");

    // A selected pair that stays open can never produce a counted edge.
    property p_open_no_count;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        (!pins_s.src_sel && $stable(pins_s.src_sel)
            && !pins_s.pecl_true_driven && !pins_s.pecl_comp_driven
            && !$past(pins_s.pecl_true_driven) && !$past(pins_s.pecl_comp_driven))
            |-> !clk_rise;
    endproperty
    a_open_no_count: assert property (p_open_no_count) else $error("open pair counted");

    property p_aligned;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        $rose(quarter_rate_outs[0]) |-> $rose(half_rate_outs[0])
            && (half_rate_outs == {NUM_HALF{1'b1}})
            && (quarter_rate_outs == {NUM_QUARTER{1'b1}});
    endproperty
    a_aligned: assert property (p_aligned) else $error("rate groups not aligned");

    property p_div_ratio;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        clk_rise |=> (half_rate_outs[0] != $past(half_rate_outs[0]))
            && ($changed(quarter_rate_outs[0]) == !$past(half_rate_outs[0]));
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("division ratio wrong");

    property p_hold_no_edge;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        !clk_rise |=> $stable(phase) && $stable(half_rate_outs) && $stable(quarter_rate_outs);
    endproperty
    a_hold_no_edge: assert property (p_hold_no_edge) else $error("divider moved w/o edge");

    property p_cov_ttl_run;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        pins_s.src_sel && $rose(quarter_rate_outs[0]);
    endproperty
    c_cov_ttl_run: cover property (p_cov_ttl_run);

    property p_cov_pecl_run;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        !pins_s.src_sel && $fell(quarter_rate_outs[0]);
    endproperty
    c_cov_pecl_run: cover property (p_cov_pecl_run);

    property p_cov_open;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        !pins_s.pecl_true_driven && !pins_s.pecl_comp_driven && !pins_s.src_sel;
    endproperty
    c_cov_open: cover property (p_cov_open);

    // Reset that arrives while the quarter group is high.
    property p_cov_reset_mid;
        @(posedge ref_clk)
        $fell(rst_n) && $past(quarter_rate_outs[0]);
    endproperty
    c_cov_reset_mid: cover property (p_cov_reset_mid);

endmodule // scd_divider

// File: rtl/scd_pkg.sv
// Shared constants and carrier types of the selectable clock divider.
// Assumes a single sampling clock; the divided clocks are rebuilt from it.
package scd_pkg;

    // Division ratios of the two output groups.
    localparam int HALF_DIV = 2;
    localparam int QUARTER_DIV = 4;

    // Default number of outputs in each group.
    localparam int NUM_HALF = 2;
    localparam int NUM_QUARTER = 6;

    // Width of the common phase counter; it spans one quarter-rate period.
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PHASE_RST = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_STEP = 2'h1;

    // Source choice encoding.
    localparam logic SEL_PECL = 1'b0;
    localparam logic SEL_TTL = 1'b1;

    // Resting level of the differential pair when both lines float.
    localparam logic PECL_OPEN_TRUE = 1'b0;
    localparam logic PECL_OPEN_COMP = 1'b1;

    // Reset level of every divided clock output.
    localparam logic LEVEL_RST = 1'b0;

    // Reset level of the receiver and edge detector: high, so that a source
    // already high when reset ends must fall once before a rise is counted.
    localparam logic ARM_LEVEL_RST = 1'b1;

    // Width of the pin bundle below.
    localparam int PINS_W = 6;

    // Input pins of the device, all asynchronous to ref_clk.
    typedef struct packed {
        logic src_sel;          // Low picks the differential pair, high the TTL input.
        logic ttl_clock_in;     // Single-ended clock.
        logic pecl_true_in;     // Non-inverting side of the pair.
        logic pecl_comp_in;     // Inverting side of the pair.
        logic pecl_true_driven; // High while something drives the true line.
        logic pecl_comp_driven; // High while something drives the complement line.
    } scd_pins_t;

endpackage : scd_pkg

// File: rtl/scd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; bits may resolve on different cycles.
module scd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    // Only the second flop may be read; the first can be metastable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end

    initial begin
        if (WIDTH < 1) begin
            $error("scd_sync: WIDTH must be at least 1");
        end
    end

endmodule // scd_sync

// File: tb/scd_osc_model.sv
// Far-side clock source: a gated oscillator that makes a set number of rises.
// Assumes ref_clk as its time base; the clock stands low between bursts.
module scd_osc_model #(
    parameter int HALF_PER = 4
) (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic [3:0] num_rises,
    output logic clk_out,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lvl = 1'b0;
    logic run = 1'b0;
    int left;
    int cnt;
    assign clk_out = lvl;
    assign busy = run;
    // Each level lasts HALF_PER cycles, so the source stays below the divider's limit.
    always @(posedge ref_clk) begin
        if (start && !run) begin
            run <= 1'b1;
            left <= 2 * num_rises;
            cnt <= 0;
        end else if (run && cnt < HALF_PER - 1) begin
            cnt <= cnt + 1;
        end else if (run) begin
            cnt <= 0;
            if (left == 0) begin
                run <= 1'b0;
            end else begin
                lvl <= ~lvl;
                left <= left - 1;
            end
        end
    end
endmodule // scd_osc_model

// File: tb/tb_top.sv
// Self-checking bench for the selectable clock divider.
// Assumes two oscillator models, one per input; both rest low when idle.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst_n, sel, drv, t_go, p_go, t_clk, p_clk, t_busy, p_busy;
    logic [3:0] t_n, p_n;
    logic [1:0] half_rate_outs;
    logic [5:0] quarter_rate_outs;
    scd_pkg::scd_pins_t pins;
    int num_errors, n_compared, k;
    // Floating pair lines still carry the clock, so only the driven flags mark them open.
    assign pins = {sel, t_clk, p_clk, ~p_clk, drv, drv};
    scd_divider dut (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
        .half_rate_outs(half_rate_outs), .quarter_rate_outs(quarter_rate_outs));
    scd_osc_model osc_t (.ref_clk(ref_clk), .start(t_go), .num_rises(t_n),
        .clk_out(t_clk), .busy(t_busy));
    scd_osc_model osc_p (.ref_clk(ref_clk), .start(p_go), .num_rises(p_n),
        .clk_out(p_clk), .busy(p_busy));
    ////////////////////////////////////////////////////////////
    // The 40 MHz sampling clock.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [1:0] h, input logic [5:0] q);
        n_compared++;
        if (half_rate_outs !== h || quarter_rate_outs !== q) begin
            num_errors++;
            $display("wrong value at %0t: outputs %b %b", $time, half_rate_outs, quarter_rate_outs);
        end
    endtask
    // After k counted rises the half group is high for odd k; the quarter group
    // is high after the first and second rise of every four, so both rise together.
    task automatic chk_k();
        logic [1:0] h;
        logic [5:0] q;
        h = ((k % 2) == 1) ? 2'h3 : 2'h0;
        q = ((k % 4) == 1 || (k % 4) == 2) ? 6'h3f : 6'h00;
        chk(h, q);
    endtask
    // Runs n rises on one source and waits, bounded, until it has gone quiet.
    task automatic burst(input logic ttl, input logic [3:0] n);
        int i;
        @(posedge ref_clk);
        #2;
        if (ttl) begin
            t_n = n;
            t_go = 1'b1;
        end else begin
            p_n = n;
            p_go = 1'b1;
        end
        @(posedge ref_clk);
        #2;
        t_go = 1'b0;
        p_go = 1'b0;
        for (i = 0; i < 400 && (t_busy || p_busy); i++) @(posedge ref_clk);
        if (i == 400) begin
            num_errors++;
            tally_and_finish();
        end
        repeat (2) @(posedge ref_clk);
        #2;
    endtask
    task automatic t_ttl_seq();
        sel = 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            burst(1'b1, 4'h1);
            k++;
            chk_k();
        end
        $display("ttl sequence done");
    endtask
    task automatic t_pecl_sel();
        sel = 1'b0;
        repeat (4) @(posedge ref_clk);
        burst(1'b1, 4'h2);
        chk_k();
        burst(1'b0, 4'h3);
        k += 3;
        chk_k();
        $display("pecl select done");
    endtask
    task automatic t_pecl_open();
        drv = 1'b0;
        repeat (4) @(posedge ref_clk);
        burst(1'b0, 4'h3);
        chk_k();
        drv = 1'b1;
        repeat (4) @(posedge ref_clk);
        #2;
        $display("open pair done");
    endtask
    task automatic t_ttl_unsel();
        sel = 1'b1;
        repeat (4) @(posedge ref_clk);
        burst(1'b0, 4'h2);
        chk_k();
        burst(1'b1, 4'h1);
        k++;
        chk_k();
        $display("ttl reselect done");
    endtask
    // Reset lands with both groups high, so a missed clear would show.
    task automatic t_reset_mid();
        @(posedge ref_clk);
        #2;
        rst_n = 1'b0;
        #1;
        chk(2'h0, 6'h00);
        burst(1'b1, 4'h2);
        chk(2'h0, 6'h00);
        rst_n = 1'b1;
        k = 0;
        repeat (4) @(posedge ref_clk);
        burst(1'b1, 4'h1);
        k++;
        chk_k();
        $display("mid-run reset done");
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {rst_n, t_go, p_go, t_n, p_n} = '0;
        sel = 1'b1;
        drv = 1'b1;
        {num_errors, n_compared, k} = '0;
        repeat (12) @(posedge ref_clk);
        #2;
        chk(2'h0, 6'h00);
        rst_n = 1'b1;
        t_ttl_seq();
        t_pecl_sel();
        t_pecl_open();
        t_ttl_unsel();
        t_reset_mid();
        tally_and_finish();
    end
endmodule // tb_top
